// >>> rtl/ppis_port_ctl.sv
`timescale 1ns/100ps
// Operation
// RULE1 - bit 3 inverts transmit positive data pin
// RULE2 - bit 2 inverts transmit line clock
// RULE3 - bit 1 inverts transmit output clock
// RULE4 - bit 0 inverts transmit input clock
// RULE5 - bits 14,13 invert payload data, enable-in
// RULE6 - bits 12,10 invert sof-out, payload overhead
// RULE7 - bits 9,7,6 invert overhead sof, data, clock
// RULE8 - bits 4,3 invert negative and positive rails
// RULE9 - bits 2,1 invert receive line, output clocks
// RULE10 - summary bit 9 from enabled latched status
// RULE11 - summary bit 8 from line code block
// RULE12 - summary bits 7..4 from their blocks
// RULE13 - summary bit 3 from either FIFO block
// RULE14 - bits 2..0 from active block only
// RULE15 - interrupt when summary set and port enabled
// RULE16 - update complete is AND of active updates
// RULE17 - host holds request until complete reads high
// RULE18 - latch update complete on rising edge
// RULE19 - enabled latched update feeds summary bit 9
// RULE20 - interrupt needs latched, enable, global enable
// RULE21 - latch receive and transmit clock activity
// RULE22 - XOR inversion at pins, enables reset zero
// RULE23 - latched bits write-one-clear, summary self-clears
module ppis_port_ctl #(
	parameter int ADDR_W = 10,
	parameter int PM_W = 4,
	parameter int SRC_W = 8
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// transmit pins and core side
	input wire logic core_tx_pos,
	input wire logic core_tx_line_clk,
	input wire logic core_tx_out_clk,
	output logic tx_pos_rail_pin,
	output logic tx_line_clk_pin,
	output logic tx_out_clk_pin,
	input wire logic tx_in_clk_pin,
	output logic core_tx_in_clk,
	// receive pins entering the port
	input wire logic rx_ovh_enable_in_pin,
	input wire logic rx_neg_rail_pin,
	input wire logic rx_pos_rail_pin,
	input wire logic rx_line_clk_pin,
	output logic core_rx_ovh_enable_in,
	output logic core_rx_neg_rail,
	output logic core_rx_pos_rail,
	output logic core_rx_line_clk,
	// receive pins leaving the port
	input wire logic core_rx_payload_data,
	input wire logic core_rx_sof_enable_out,
	input wire logic core_rx_payload_ovh,
	input wire logic core_rx_ovh_sof,
	input wire logic core_rx_ovh_data,
	input wire logic core_rx_ovh_clk,
	input wire logic core_rx_out_clk,
	output logic rx_payload_data_pin,
	output logic rx_sof_enable_out_pin,
	output logic rx_payload_ovh_pin,
	output logic rx_ovh_sof_pin,
	output logic rx_ovh_data_pin,
	output logic rx_ovh_clk_pin,
	output logic rx_out_clk_pin,
	// enabled latched status from the sub-blocks
	input wire logic [SRC_W-1:0] line_code_status,
	input wire logic [SRC_W-1:0] trail_trace_status,
	input wire logic [SRC_W-1:0] far_end_alarm_status,
	input wire logic [SRC_W-1:0] hdlc_status,
	input wire logic [SRC_W-1:0] bit_error_test_status,
	input wire logic [SRC_W-1:0] tx_fifo_status,
	input wire logic [SRC_W-1:0] rx_fifo_status,
	input wire logic [SRC_W-1:0] cell_status,
	input wire logic [SRC_W-1:0] packet_status,
	input wire logic packet_mode,
	input wire logic [SRC_W-1:0] plcp_status,
	input wire logic plcp_active,
	input wire logic [SRC_W-1:0] ds3_framer_status,
	input wire logic [SRC_W-1:0] e3_framer_status,
	input wire logic e3_mode,
	// performance monitoring update
	input wire logic [PM_W-1:0] pm_update_active,
	input wire logic [PM_W-1:0] pm_update_done,
	output logic port_update_request,
	// interrupt
	output logic port_irq
);

	// widths that the decode and the update AND cannot serve; refused at elaboration
	if (ADDR_W < ppis_pkg::IDX_W + 2 || PM_W < 1 || SRC_W < 1) begin : g_bad_params
		$error("ppis_port_ctl: unsupported parameter values");
	end

	// word index of a byte address; taken in the address phase and held in idx_r for the data phase
	function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
		idx_of = a[ppis_pkg::IDX_W+1:2];
	endfunction

	logic [15:0] inv1_r;
	logic [15:0] inv2_r;
	logic [15:0] latched_r;
	logic [15:0] irq_en_r;
	logic [15:0] port_ctl_r;
	logic [15:0] summary;
	logic [15:0] live;
	logic update_complete;
	logic update_complete_prev_r;
	logic rx_line_clk_prev_r;
	logic tx_in_clk_prev_r;
	logic wr_pend_r;
	logic rd_pend_r;
	logic [7:0] idx_r;
	logic [15:0] rd_val;
	logic irq_r;

	// transmit pin inversion, a plain XOR at the pin boundary
	assign tx_pos_rail_pin = core_tx_pos ^ inv1_r[ppis_pkg::TX_POS_DATA_INVERT]; // RULE1 RULE22
	assign tx_line_clk_pin = core_tx_line_clk ^ inv1_r[ppis_pkg::TX_LINE_CLK_INVERT]; // RULE2
	assign tx_out_clk_pin = core_tx_out_clk ^ inv1_r[ppis_pkg::TX_OUT_CLK_INVERT]; // RULE3
	assign core_tx_in_clk = tx_in_clk_pin ^ inv1_r[ppis_pkg::TX_IN_CLK_INVERT]; // RULE4

	// receive pin inversion
	assign rx_payload_data_pin = core_rx_payload_data
		^ inv2_r[ppis_pkg::RX_PAYLOAD_DATA_INVERT]; // RULE5
	assign core_rx_ovh_enable_in = rx_ovh_enable_in_pin
		^ inv2_r[ppis_pkg::RX_OVH_ENABLE_IN_INVERT]; // RULE5
	assign rx_sof_enable_out_pin = core_rx_sof_enable_out
		^ inv2_r[ppis_pkg::RX_SOF_ENABLE_OUT_INVERT]; // RULE6
	assign rx_payload_ovh_pin = core_rx_payload_ovh
		^ inv2_r[ppis_pkg::RX_PAYLOAD_OVH_INVERT]; // RULE6
	assign rx_ovh_sof_pin = core_rx_ovh_sof ^ inv2_r[ppis_pkg::RX_OVH_SOF_INVERT]; // RULE7
	assign rx_ovh_data_pin = core_rx_ovh_data ^ inv2_r[ppis_pkg::RX_OVH_DATA_INVERT]; // RULE7
	assign rx_ovh_clk_pin = core_rx_ovh_clk ^ inv2_r[ppis_pkg::RX_OVH_CLK_INVERT]; // RULE7
	assign core_rx_neg_rail = rx_neg_rail_pin ^ inv2_r[ppis_pkg::RX_NEG_RAIL_INVERT]; // RULE8
	assign core_rx_pos_rail = rx_pos_rail_pin ^ inv2_r[ppis_pkg::RX_POS_RAIL_INVERT]; // RULE8
	assign core_rx_line_clk = rx_line_clk_pin ^ inv2_r[ppis_pkg::RX_LINE_CLK_INVERT]; // RULE9
	assign rx_out_clk_pin = core_rx_out_clk ^ inv2_r[ppis_pkg::RX_OUT_CLK_INVERT]; // RULE9

	// an inactive update signal must not hold the AND low
	assign update_complete = &(pm_update_done | ~pm_update_active); // RULE16
	assign port_update_request = port_ctl_r[ppis_pkg::PORT_UPDATE_REQUEST]; // RULE17

	// live status view
	always_comb begin
		live = ppis_pkg::REG_RST;
		live[ppis_pkg::UPDATE_COMPLETE] = update_complete;
	end

	// summary is pure logic so it clears by itself once sources drop
	always_comb begin
		summary = ppis_pkg::REG_RST;
		summary[ppis_pkg::PORT_STATUS_SUMMARY] = |(latched_r & irq_en_r); // RULE10 RULE19 RULE23
		summary[ppis_pkg::LINE_CODE_SUMMARY] = |line_code_status; // RULE11
		summary[ppis_pkg::TRAIL_TRACE_SUMMARY] = |trail_trace_status; // RULE12
		summary[ppis_pkg::FAR_END_ALARM_SUMMARY] = |far_end_alarm_status; // RULE12
		summary[ppis_pkg::HDLC_SUMMARY] = |hdlc_status; // RULE12
		summary[ppis_pkg::BIT_ERROR_TEST_SUMMARY] = |bit_error_test_status; // RULE12
		summary[ppis_pkg::SYSTEM_FIFO_SUMMARY] = |(tx_fifo_status | rx_fifo_status); // RULE13
		summary[ppis_pkg::CELL_PACKET_SUMMARY] = packet_mode ? |packet_status
			: |cell_status; // RULE14
		summary[ppis_pkg::PLCP_SUMMARY] = plcp_active & (|plcp_status); // RULE14
		summary[ppis_pkg::FRAMER_SUMMARY] = e3_mode ? |e3_framer_status
			: |ds3_framer_status; // RULE14
	end

	// interrupt output, one flop after the summary
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (|summary) & port_ctl_r[ppis_pkg::GLOBAL_PORT_IRQ_ENABLE]; // RULE15 RULE20
		end
	end
	assign port_irq = irq_r;

	// bus address phase capture; a write lands in the next data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			idx_r <= 8'h00;
		end else if (rd_pend_r) begin
			rd_pend_r <= 1'b0;
		end else if (hready) begin
			wr_pend_r <= hsel & htrans[1] & hwrite;
			rd_pend_r <= hsel & htrans[1] & ~hwrite;
			idx_r <= idx_of(haddr);
		end
	end

	// reads take one wait state so that hrdata comes from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pend_r) begin
			hrdata <= {16'h0000, rd_val};
		end
	end
	assign hreadyout = ~rd_pend_r;
	assign hresp = 1'b0;

	// read mux; unmapped indices read as zero
	always_comb begin
		case (idx_r)
			ppis_pkg::IDX_INV1: rd_val = inv1_r;
			ppis_pkg::IDX_INV2: rd_val = inv2_r;
			ppis_pkg::IDX_SUMMARY: rd_val = summary;
			ppis_pkg::IDX_LIVE: rd_val = live;
			ppis_pkg::IDX_LATCHED: rd_val = latched_r;
			ppis_pkg::IDX_IRQ_EN: rd_val = irq_en_r;
			ppis_pkg::IDX_PORT_CTL: rd_val = port_ctl_r;
			default: rd_val = ppis_pkg::REG_RST;
		endcase
	end

	// control registers; reserved bits are masked off and read zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			inv1_r <= ppis_pkg::REG_RST; // RULE22
			inv2_r <= ppis_pkg::REG_RST; // RULE22
			irq_en_r <= ppis_pkg::REG_RST; // RULE22
			port_ctl_r <= ppis_pkg::REG_RST;
		end else if (wr_pend_r) begin
			case (idx_r)
				ppis_pkg::IDX_INV1: inv1_r <= hwdata[15:0] & ppis_pkg::INV1_MASK;
				ppis_pkg::IDX_INV2: inv2_r <= hwdata[15:0] & ppis_pkg::INV2_MASK;
				ppis_pkg::IDX_IRQ_EN: irq_en_r <= hwdata[15:0] & ppis_pkg::LATCH_MASK;
				ppis_pkg::IDX_PORT_CTL: port_ctl_r <= hwdata[15:0] & ppis_pkg::PORT_CTL_MASK;
				default: ;
			endcase
		end
	end

	// previous samples for edge and activity detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			update_complete_prev_r <= 1'b0;
			rx_line_clk_prev_r <= 1'b0;
			tx_in_clk_prev_r <= 1'b0;
		end else begin
			update_complete_prev_r <= update_complete;
			rx_line_clk_prev_r <= rx_line_clk_pin;
			tx_in_clk_prev_r <= tx_in_clk_pin;
		end
	end

	// latched status: a set in the same cycle as a clear wins
	logic [15:0] latch_set;
	logic [15:0] latch_clr;
	always_comb begin
		latch_set = ppis_pkg::REG_RST;
		latch_set[ppis_pkg::UPDATE_COMPLETE] = update_complete
			& ~update_complete_prev_r; // RULE18
		latch_set[ppis_pkg::RX_LINE_CLK_ACTIVITY] = rx_line_clk_pin
			^ rx_line_clk_prev_r; // RULE21
		latch_set[ppis_pkg::TX_IN_CLK_ACTIVITY] = tx_in_clk_pin ^ tx_in_clk_prev_r; // RULE21
		latch_clr = ppis_pkg::REG_RST;
		if (wr_pend_r && idx_r == ppis_pkg::IDX_LATCHED) begin
			latch_clr = hwdata[15:0] & ppis_pkg::LATCH_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latched_r <= ppis_pkg::REG_RST;
		end else begin
			latched_r <= (latched_r & ~latch_clr) | latch_set; // RULE23
		end
	end

	// checks kept beside the logic they guard
	sequence s_uc_rise;
		!update_complete ##1 update_complete;
	endsequence

	// latched bit set with no clearing write aimed at it in this cycle
	sequence s_latch_keep;
		latched_r[ppis_pkg::UPDATE_COMPLETE] && !(wr_pend_r
			&& idx_r == ppis_pkg::IDX_LATCHED && hwdata[ppis_pkg::UPDATE_COMPLETE]);
	endsequence

	property p_tx_pos;
		@(posedge hclk) disable iff (!hresetn)
		tx_pos_rail_pin == (core_tx_pos ^ inv1_r[ppis_pkg::TX_POS_DATA_INVERT]);
	endproperty
	a_tx_pos: assert property (p_tx_pos) else $error("tx pos inversion wrong"); // RULE1

	property p_tx_in_clk;
		@(posedge hclk) disable iff (!hresetn)
		$rose(inv1_r[ppis_pkg::TX_IN_CLK_INVERT]) |-> core_tx_in_clk == !tx_in_clk_pin;
	endproperty
	a_tx_in_clk: assert property (p_tx_in_clk) else $error("tx in clk not inverted"); // RULE4

	property p_rx_neg;
		@(posedge hclk) disable iff (!hresetn)
		core_rx_neg_rail == (rx_neg_rail_pin ^ inv2_r[ppis_pkg::RX_NEG_RAIL_INVERT]);
	endproperty
	a_rx_neg: assert property (p_rx_neg) else $error("rx neg inversion wrong"); // RULE8

	property p_uc_latch;
		@(posedge hclk) disable iff (!hresetn)
		s_uc_rise |=> latched_r[ppis_pkg::UPDATE_COMPLETE];
	endproperty
	a_uc_latch: assert property (p_uc_latch) else $error("update complete not latched"); // RULE18

	property p_latch_hold;
		@(posedge hclk) disable iff (!hresetn)
		s_latch_keep |=> latched_r[ppis_pkg::UPDATE_COMPLETE];
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched bit lost"); // RULE23

	property p_psr;
		@(posedge hclk) disable iff (!hresetn)
		latched_r[ppis_pkg::UPDATE_COMPLETE] && irq_en_r[ppis_pkg::UPDATE_COMPLETE]
			|-> summary[ppis_pkg::PORT_STATUS_SUMMARY];
	endproperty
	a_psr: assert property (p_psr) else $error("port status summary missing"); // RULE19

	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		(|summary) && port_ctl_r[ppis_pkg::GLOBAL_PORT_IRQ_ENABLE] |=> port_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not driven"); // RULE15

	property p_irq_gate;
		@(posedge hclk) disable iff (!hresetn)
		!port_ctl_r[ppis_pkg::GLOBAL_PORT_IRQ_ENABLE] |=> !port_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable"); // RULE20

	property p_rx_act;
		@(posedge hclk) disable iff (!hresetn)
		$changed(rx_line_clk_pin) |=> latched_r[ppis_pkg::RX_LINE_CLK_ACTIVITY];
	endproperty
	a_rx_act: assert property (p_rx_act) else $error("rx clock activity missed"); // RULE21

	property p_fifo;
		@(posedge hclk) disable iff (!hresetn)
		(|rx_fifo_status) |-> summary[ppis_pkg::SYSTEM_FIFO_SUMMARY];
	endproperty
	a_fifo: assert property (p_fifo) else $error("fifo summary missing"); // RULE13

	property p_framer;
		@(posedge hclk) disable iff (!hresetn)
		e3_mode && !(|e3_framer_status) |-> !summary[ppis_pkg::FRAMER_SUMMARY];
	endproperty
	a_framer: assert property (p_framer) else $error("inactive framer leaked"); // RULE14

	property p_uc_and;
		@(posedge hclk) disable iff (!hresetn)
		|(pm_update_active & ~pm_update_done) |-> !live[ppis_pkg::UPDATE_COMPLETE];
	endproperty
	a_uc_and: assert property (p_uc_and) else $error("update complete too early"); // RULE16

	property p_read_wait;
		@(posedge hclk) disable iff (!hresetn)
		hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule

// >>> shared/ppis_pkg.sv
package ppis_pkg;
	// register width and reset value
	localparam int REG_W = 16;
	localparam logic [15:0] REG_RST = 16'h0000;

	// register indices; byte address is index times four
	localparam int IDX_W = 8;
	localparam logic [7:0] IDX_INV1 = 8'h4a;
	localparam logic [7:0] IDX_INV2 = 8'h4c;
	localparam logic [7:0] IDX_SUMMARY = 8'h50;
	localparam logic [7:0] IDX_LIVE = 8'h52;
	localparam logic [7:0] IDX_LATCHED = 8'h54;
	localparam logic [7:0] IDX_IRQ_EN = 8'h56;
	localparam logic [7:0] IDX_PORT_CTL = 8'h58;

	// first pin-inversion register fields
	localparam int TX_POS_DATA_INVERT = 3;
	localparam int TX_LINE_CLK_INVERT = 2;
	localparam int TX_OUT_CLK_INVERT = 1;
	localparam int TX_IN_CLK_INVERT = 0;
	localparam logic [15:0] INV1_MASK = 16'h000f;

	// second pin-inversion register fields
	localparam int RX_PAYLOAD_DATA_INVERT = 14;
	localparam int RX_OVH_ENABLE_IN_INVERT = 13;
	localparam int RX_SOF_ENABLE_OUT_INVERT = 12;
	localparam int RX_PAYLOAD_OVH_INVERT = 10;
	localparam int RX_OVH_SOF_INVERT = 9;
	localparam int RX_OVH_DATA_INVERT = 7;
	localparam int RX_OVH_CLK_INVERT = 6;
	localparam int RX_NEG_RAIL_INVERT = 4;
	localparam int RX_POS_RAIL_INVERT = 3;
	localparam int RX_LINE_CLK_INVERT = 2;
	localparam int RX_OUT_CLK_INVERT = 1;
	localparam logic [15:0] INV2_MASK = 16'h76de;

	// summary register fields
	localparam int PORT_STATUS_SUMMARY = 9;
	localparam int LINE_CODE_SUMMARY = 8;
	localparam int TRAIL_TRACE_SUMMARY = 7;
	localparam int FAR_END_ALARM_SUMMARY = 6;
	localparam int HDLC_SUMMARY = 5;
	localparam int BIT_ERROR_TEST_SUMMARY = 4;
	localparam int SYSTEM_FIFO_SUMMARY = 3;
	localparam int CELL_PACKET_SUMMARY = 2;
	localparam int PLCP_SUMMARY = 1;
	localparam int FRAMER_SUMMARY = 0;

	// live, latched and enable fields
	localparam int UPDATE_COMPLETE = 0;
	localparam int RX_LINE_CLK_ACTIVITY = 7;
	localparam int TX_IN_CLK_ACTIVITY = 6;
	localparam logic [15:0] LATCH_MASK = 16'h00c1;

	// port control register fields
	localparam int PORT_UPDATE_REQUEST = 0;
	localparam int GLOBAL_PORT_IRQ_ENABLE = 1;
	localparam logic [15:0] PORT_CTL_MASK = 16'h0003;

	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	// clock, reset and bus
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [9:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	// one level drives every pin and core input so all inversions are seen together
	logic v_in;
	logic [3:0] tx_o;
	logic [10:0] rx_o;
	logic [7:0] src [0:11];
	logic packet_mode, plcp_active, e3_mode;
	logic [3:0] pm_active;
	logic [3:0] pm_done;
	logic upd_req;
	logic port_irq;
	logic [31:0] exp_v;
	int sbit [0:11] = '{8, 7, 6, 5, 4, 3, 3, 2, 2, 1, 0, 0};
	int bad_count;
	int num_checks;

	// device under test; hready is the slave's own hreadyout
	ppis_port_ctl ppis_port_ctl_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.core_tx_pos(v_in), .core_tx_line_clk(v_in), .core_tx_out_clk(v_in),
		.tx_pos_rail_pin(tx_o[3]), .tx_line_clk_pin(tx_o[2]), .tx_out_clk_pin(tx_o[1]),
		.tx_in_clk_pin(v_in), .core_tx_in_clk(tx_o[0]),
		.rx_ovh_enable_in_pin(v_in), .rx_neg_rail_pin(v_in), .rx_pos_rail_pin(v_in),
		.rx_line_clk_pin(v_in), .core_rx_ovh_enable_in(rx_o[9]), .core_rx_neg_rail(rx_o[3]),
		.core_rx_pos_rail(rx_o[2]), .core_rx_line_clk(rx_o[1]),
		.core_rx_payload_data(v_in), .core_rx_sof_enable_out(v_in), .core_rx_payload_ovh(v_in),
		.core_rx_ovh_sof(v_in), .core_rx_ovh_data(v_in), .core_rx_ovh_clk(v_in),
		.core_rx_out_clk(v_in), .rx_payload_data_pin(rx_o[10]), .rx_sof_enable_out_pin(rx_o[8]),
		.rx_payload_ovh_pin(rx_o[7]), .rx_ovh_sof_pin(rx_o[6]), .rx_ovh_data_pin(rx_o[5]),
		.rx_ovh_clk_pin(rx_o[4]), .rx_out_clk_pin(rx_o[0]),
		.line_code_status(src[0]), .trail_trace_status(src[1]), .far_end_alarm_status(src[2]),
		.hdlc_status(src[3]), .bit_error_test_status(src[4]), .tx_fifo_status(src[5]),
		.rx_fifo_status(src[6]), .cell_status(src[7]), .packet_status(src[8]),
		.packet_mode(packet_mode), .plcp_status(src[9]), .plcp_active(plcp_active),
		.ds3_framer_status(src[10]), .e3_framer_status(src[11]), .e3_mode(e3_mode),
		.pm_update_active(pm_active), .pm_update_done(pm_done),
		.port_update_request(upd_req), .port_irq(port_irq)
	);

	// free-running bus clock
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// verdict; every path that gives up ends here
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// the slave may stretch any phase, so wait on hready rather than a fixed count
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				bad_count++;
				$display("BAD %0t bus answer never came", $time);
				close_out();
			end
			@(posedge hclk);
		end
	endtask

	// one single-word transfer; entered and left just after a rising edge
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {idx, 2'b00};
		htrans <= ppis_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] unused;
		bus(1'b1, idx, wd, unused);
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] got;
		bus(1'b0, idx, 32'h0000_0000, got);
		chk(got, exp);
	endtask

	// both input levels against the given inversion settings
	task automatic pin_chk(input logic [15:0] inv1, input logic [15:0] inv2);
		logic [10:0] rx_exp;
		for (int v = 0; v < 2; v++) begin
			v_in <= v[0];
			@(negedge hclk);
			rx_exp = {11{v[0]}} ^ {inv2[14:12], inv2[10:9], inv2[7:6], inv2[4:1]};
			chk({28'h0, tx_o}, {28'h0, {4{v[0]}} ^ inv1[3:0]});
			chk({21'h0, rx_o}, {21'h0, rx_exp});
			@(posedge hclk);
		end
	endtask

	// main sequence
	initial begin
		hsel = 1'b0;
		haddr = 10'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = ppis_pkg::HSIZE_WORD;
		hwdata = 32'h0000_0000;
		v_in = 1'b0;
		packet_mode = 1'b0;
		plcp_active = 1'b0;
		e3_mode = 1'b0;
		pm_active = 4'hf;
		pm_done = 4'h0;
		for (int i = 0; i < 12; i++) src[i] = 8'h00;
		bad_count = 0;
		num_checks = 0;
		hresetn = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values, unmapped place and reserved bits
		rd_chk(ppis_pkg::IDX_INV1, 32'h0000_0000);
		rd_chk(ppis_pkg::IDX_INV2, 32'h0000_0000);
		rd_chk(ppis_pkg::IDX_IRQ_EN, 32'h0000_0000);
		rd_chk(ppis_pkg::IDX_LATCHED, 32'h0000_0000);
		rd_chk(ppis_pkg::IDX_SUMMARY, 32'h0000_0000);
		chk({31'h0, hresp}, 32'h0000_0000);
		wr(8'h4e, 32'hffff_ffff);
		rd_chk(8'h4e, 32'h0000_0000);
		pin_chk(16'h0000, 16'h0000);
		wr(ppis_pkg::IDX_INV1, 32'hffff_ffff);
		rd_chk(ppis_pkg::IDX_INV1, 32'h0000_000f);
		wr(ppis_pkg::IDX_INV2, 32'hffff_ffff);
		rd_chk(ppis_pkg::IDX_INV2, 32'h0000_76de);
		// two complementary patterns catch swapped or stuck control bits
		wr(ppis_pkg::IDX_INV1, 32'h0000_000a);
		wr(ppis_pkg::IDX_INV2, 32'h0000_524a);
		pin_chk(16'h000a, 16'h524a);
		wr(ppis_pkg::IDX_INV1, 32'h0000_0005);
		wr(ppis_pkg::IDX_INV2, 32'h0000_2494);
		pin_chk(16'h0005, 16'h2494);
		// clock pins toggled above, so both activity bits are latched
		rd_chk(ppis_pkg::IDX_LATCHED, 32'h0000_00c0);
		wr(ppis_pkg::IDX_LATCHED, 32'h0000_0040);
		rd_chk(ppis_pkg::IDX_LATCHED, 32'h0000_0080);
		wr(ppis_pkg::IDX_IRQ_EN, 32'hffff_ffff);
		rd_chk(ppis_pkg::IDX_IRQ_EN, 32'h0000_00c1);
		rd_chk(ppis_pkg::IDX_SUMMARY, 32'h0000_0200);
		wr(ppis_pkg::IDX_LATCHED, 32'h0000_0080);
		rd_chk(ppis_pkg::IDX_SUMMARY, 32'h0000_0000);
		// each sub-block source, with its selector right and then wrong
		wr(ppis_pkg::IDX_PORT_CTL, 32'h0000_0002);
		for (int k = 0; k < 12; k++) begin
			for (int p = 0; p < 2; p++) begin
				packet_mode <= (k == 8) ^ p[0];
				plcp_active <= (k == 9) ^ p[0];
				e3_mode <= (k == 11) ^ p[0];
				src[k] <= k[0] ? 8'h80 : 8'h01;
				exp_v = (k < 7 || p == 0) ? (32'h1 << sbit[k]) : 32'h0;
				rd_chk(ppis_pkg::IDX_SUMMARY, exp_v);
				chk({31'h0, port_irq}, {31'h0, exp_v != 0});
			end
			src[k] <= 8'h00;
		end
		src[0] <= 8'h10;
		wr(ppis_pkg::IDX_PORT_CTL, 32'h0000_0000);
		rd_chk(ppis_pkg::IDX_SUMMARY, 32'h0000_0100);
		chk({31'h0, port_irq}, 32'h0000_0000);
		src[0] <= 8'h00;
		// update request held until completion reads high
		wr(ppis_pkg::IDX_IRQ_EN, 32'h0000_0001);
		wr(ppis_pkg::IDX_PORT_CTL, 32'h0000_0003);
		pm_active <= 4'h5;
		pm_done <= 4'ha;
		rd_chk(ppis_pkg::IDX_LIVE, 32'h0000_0000);
		chk({31'h0, upd_req}, 32'h0000_0001);
		rd_chk(ppis_pkg::IDX_LATCHED, 32'h0000_0000);
		pm_done <= 4'h5;
		rd_chk(ppis_pkg::IDX_LIVE, 32'h0000_0001);
		rd_chk(ppis_pkg::IDX_LATCHED, 32'h0000_0001);
		rd_chk(ppis_pkg::IDX_SUMMARY, 32'h0000_0200);
		chk({31'h0, port_irq}, 32'h0000_0001);
		wr(ppis_pkg::IDX_PORT_CTL, 32'h0000_0000);
		rd_chk(ppis_pkg::IDX_SUMMARY, 32'h0000_0200);
		chk({31'h0, port_irq}, 32'h0000_0000);
		chk({31'h0, upd_req}, 32'h0000_0000);
		wr(ppis_pkg::IDX_PORT_CTL, 32'h0000_0002);
		wr(ppis_pkg::IDX_IRQ_EN, 32'h0000_0000);
		rd_chk(ppis_pkg::IDX_SUMMARY, 32'h0000_0000);
		chk({31'h0, port_irq}, 32'h0000_0000);
		// a level that stays high must not latch again after clearing
		wr(ppis_pkg::IDX_LATCHED, 32'h0000_0001);
		rd_chk(ppis_pkg::IDX_LATCHED, 32'h0000_0000);
		pm_done <= 4'h4;
		rd_chk(ppis_pkg::IDX_LIVE, 32'h0000_0000);
		pm_done <= 4'h5;
		rd_chk(ppis_pkg::IDX_LATCHED, 32'h0000_0001);
		pm_active <= 4'h0;
		pm_done <= 4'h0;
		rd_chk(ppis_pkg::IDX_LIVE, 32'h0000_0001);
		close_out();
	end
endmodule
